// ### design/prs_main.sv
// Main readout sequencer: start handling, internal resets, config load, line/frame timing.
// Assumes start_i and speak_i are asynchronous pins; patterns and mask are static.
//
// How it works
// - Digital marker rises two cycles after frame begin, stays high four cycles.
// - Analogue marker is produced on its pad only while analogue readout is active.
// - Analogue clock and marker run from the moment the sequencer starts.
// - Frames repeat without end; only a new start token or resetn_i stops readout.
// - A new start token at any time restarts the frame sequence.
// - Two line ticks with start high assert both active-low sequencer resets.
// - After start falls, first row clock fall activates pixel timing during load hold.
// - Sparse-path timing is loaded in the fifth line before readout.
// - Load hold falling enables clamp, sample, read, calib, latch and discriminator controls; readout starts.
// - Every line lasts sixteen clock cycles.
// - Stage functions end at least 10 ns before the next line sync edge.
// - Pixel power-on rises when start is seen high and then stays high.
// - All 960 pixels of a row sample and discriminate together.
// - Row clock per line, second row clock per two lines, clamp once per line.
// - A set mask bit silences the matching discriminator output.
// - The mask is only taken up by a new start sequence.
// - One sequencer makes line controls; they are broadcast to every row.
// - A frame is 928 lines and frame signals repeat with that period.
// - Clamp, read, calib and latch patterns latch during reset; all patterns then recirculate as closed loops.
`timescale 1ns/100ps
module prs_main
	import prs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Controller pins
	input wire logic start_i,
	input wire logic speak_i,
	// Timing patterns, one bit per line phase
	input wire logic [15:0] clamp_pat_i,
	input wire logic [15:0] read_pat_i,
	input wire logic [15:0] calib_pat_i,
	input wire logic [15:0] latch_pat_i,
	input wire logic [15:0] sparse_pat_i,
	// Discriminators
	input wire logic [959:0] disc_mask_i,
	input wire logic [959:0] disc_raw_i,
	output logic [959:0] disc_out_o,
	// Sequencer state
	output logic seq_rst_a_n_o,
	output logic seq_rst_d_n_o,
	output logic pwr_on_o,
	output logic load_hold_o,
	output logic readout_active_o,
	output logic [9:0] row_addr_o,
	// Line and frame sync
	output logic line_sync_o,
	output logic frame_begin_o,
	output logic row_clk_o,
	output logic row_clk_evod_o,
	output logic clamp_o,
	output logic sample_o,
	output logic read_o,
	output logic calib_o,
	output logic latch_o,
	output logic sparse_sync_o,
	// Markers
	output logic dig_sync_marker_o,
	output logic analog_clk_o,
	output logic analog_marker_out_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [2:0] start_sync_reg;
	logic [2:0] speak_sync_reg;
	logic start_reg;
	logic speak_reg;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			start_sync_reg <= 3'h0;
			speak_sync_reg <= 3'h0;
			start_reg <= 1'b0;
			speak_reg <= 1'b0;
		end
		else
		begin
			start_sync_reg <= {start_sync_reg[1:0], start_i};
			speak_sync_reg <= {speak_sync_reg[1:0], speak_i};
			if (start_sync_reg[1] == start_sync_reg[2])
				start_reg <= start_sync_reg[2];
			if (speak_sync_reg[1] == speak_sync_reg[2])
				speak_reg <= speak_sync_reg[2];
		end
	end

	logic start_prev_reg;
	wire start_rise = start_reg && !start_prev_reg;
	wire start_fall = !start_reg && start_prev_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Line phase, free running so line ticks exist before and during reset

	logic [3:0] phase_reg;
	wire line_tick = (phase_reg == PHASE_LAST);
	wire row_fall = (phase_reg == PHASE_ROW_FALL);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			phase_reg <= PHASE_RST;
		else
			phase_reg <= phase_reg + 4'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start, reset and load sequence

	prs_state_t state_reg;
	prs_state_t state_next;
	logic [1:0] tick_cnt_reg;
	logic [3:0] load_cnt_reg;
	logic seq_rst_reg;
	logic pix_act_reg;
	logic started_reg;

	wire running = (state_reg == ST_RUN);
	wire rst_done = (tick_cnt_reg == RST_TICKS);
	wire load_end = (state_reg == ST_LOAD) && line_tick && (load_cnt_reg == LOAD_LAST);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				if (start_reg)
					state_next = ST_RESET;
			ST_RESET:
				if (start_fall)
					state_next = rst_done ? ST_LOAD : ST_IDLE;
			ST_LOAD:
				if (load_end)
					state_next = ST_RUN;
			ST_RUN:
				state_next = ST_RUN;
			default:
				state_next = ST_IDLE;
		endcase
		if (start_rise)
			state_next = ST_RESET;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_reg <= ST_IDLE;
			start_prev_reg <= 1'b0;
			tick_cnt_reg <= 2'h0;
			load_cnt_reg <= 4'h0;
			seq_rst_reg <= 1'b0;
			pix_act_reg <= 1'b0;
			started_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			start_prev_reg <= start_reg;
			if (state_reg != ST_RESET || start_rise)
				tick_cnt_reg <= 2'h0;
			else if (line_tick && start_reg && !rst_done)
				tick_cnt_reg <= tick_cnt_reg + 2'h1;
			if (state_reg == ST_RESET && rst_done)
				seq_rst_reg <= 1'b1;
			else if (state_next != ST_RESET)
				seq_rst_reg <= 1'b0;
			if (state_reg != ST_LOAD)
				load_cnt_reg <= 4'h0;
			else if (line_tick)
				load_cnt_reg <= load_cnt_reg + 4'h1;
			if (state_next == ST_RESET || state_next == ST_IDLE)
				pix_act_reg <= 1'b0;
			else if (state_reg == ST_LOAD && row_fall)
				pix_act_reg <= 1'b1;
			if (seq_rst_reg)
				started_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pattern rings and row counter

	wire ring_load = seq_rst_reg && line_tick;
	wire sparse_load = (state_reg == ST_LOAD) && line_tick && (load_cnt_reg == SPARSE_LINE);
	logic clamp_bit;
	logic read_bit;
	logic calib_bit;
	logic latch_bit;
	logic sparse_bit;

	prs_ring u_clamp_ring (.clk_i(clk_i), .resetn_i(resetn_i), .load_i(ring_load),
		.pattern_i(clamp_pat_i), .bit_o(clamp_bit));
	prs_ring u_read_ring (.clk_i(clk_i), .resetn_i(resetn_i), .load_i(ring_load),
		.pattern_i(read_pat_i), .bit_o(read_bit));
	prs_ring u_calib_ring (.clk_i(clk_i), .resetn_i(resetn_i), .load_i(ring_load),
		.pattern_i(calib_pat_i), .bit_o(calib_bit));
	prs_ring u_latch_ring (.clk_i(clk_i), .resetn_i(resetn_i), .load_i(ring_load),
		.pattern_i(latch_pat_i), .bit_o(latch_bit));
	// Sparse timing is latched late, in the load hold, to keep it aligned to readout
	prs_ring u_sparse_ring (.clk_i(clk_i), .resetn_i(resetn_i), .load_i(sparse_load),
		.pattern_i(sparse_pat_i), .bit_o(sparse_bit));

	logic [9:0] row_reg;
	logic evod_reg;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			row_reg <= ROW_RST;
			evod_reg <= 1'b0;
		end
		else if (seq_rst_reg)
		begin
			row_reg <= ROW_RST;
			evod_reg <= 1'b0;
		end
		else if (running && line_tick)
		begin
			row_reg <= (row_reg == ROW_LAST) ? ROW_RST : row_reg + 10'h001;
			evod_reg <= !evod_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Line signal decode, one copy broadcast to all rows

	// Last MARGIN_CYC phases stay quiet so stage work ends before next sync edge
	wire in_func = (phase_reg <= PHASE_FUNC_END);
	wire pix_en = running && pix_act_reg;
	wire fb_w = running && (row_reg == ROW_RST) && (phase_reg == PHASE_RST);
	wire row_clk_w = pix_act_reg && (phase_reg < PHASE_ROW_FALL);
	wire clamp_w = pix_en && clamp_bit && in_func;
	wire sample_w = pix_en && (phase_reg == PHASE_RST);
	wire read_w = pix_en && read_bit && in_func;
	wire calib_w = pix_en && calib_bit && in_func;
	wire latch_w = pix_en && latch_bit && in_func;
	wire sparse_w = running && sparse_bit && in_func;
	wire sync_w = running && (phase_reg == PHASE_RST);

	////////////////////////////////////////////////////////////////////////////////
	// Discriminator mask, captured only while the start sequence holds reset

	logic [959:0] mask_reg;
	logic [959:0] disc_reg;

	genvar col;
	generate
		for (col = 0; col < NUM_COLS; col++)
		begin : g_col
			always_ff @(posedge clk_i or negedge resetn_i)
			begin
				if (!resetn_i)
				begin
					mask_reg[col] <= 1'b0;
					disc_reg[col] <= 1'b0;
				end
				else
				begin
					if (seq_rst_reg)
						mask_reg[col] <= disc_mask_i[col];
					disc_reg[col] <= pix_en && disc_raw_i[col] && !mask_reg[col];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Markers and registered outputs

	logic [2:0] mk_cnt_reg;
	logic pwr_on_reg;
	logic aclk_reg;
	logic amk_reg;
	logic dmk_reg;
	logic fb_reg;
	logic [10:0] line_regs;

	wire dmk_w = (mk_cnt_reg >= MK_FIRST) && (mk_cnt_reg < MK_END);

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			mk_cnt_reg <= 3'h0;
			pwr_on_reg <= 1'b0;
			aclk_reg <= 1'b0;
			amk_reg <= 1'b0;
			dmk_reg <= 1'b0;
			fb_reg <= 1'b0;
			line_regs <= 11'h000;
		end
		else
		begin
			if (fb_reg)
				mk_cnt_reg <= MK_FIRST;
			else if (mk_cnt_reg != 3'h0 && mk_cnt_reg < MK_END)
				mk_cnt_reg <= mk_cnt_reg + 3'h1;
			else
				mk_cnt_reg <= 3'h0;
			dmk_reg <= dmk_w;
			if (start_reg)
				pwr_on_reg <= 1'b1;
			aclk_reg <= started_reg && !aclk_reg;
			amk_reg <= started_reg && speak_reg && fb_w;
			fb_reg <= fb_w;
			line_regs <= {sync_w, row_clk_w, evod_reg && pix_act_reg, clamp_w, sample_w,
				read_w, calib_w, latch_w, sparse_w, running, state_reg == ST_LOAD};
		end
	end

	assign disc_out_o = disc_reg;
	assign seq_rst_a_n_o = !seq_rst_reg;
	assign seq_rst_d_n_o = !seq_rst_reg;
	assign pwr_on_o = pwr_on_reg;
	assign load_hold_o = line_regs[0];
	assign readout_active_o = line_regs[1];
	assign row_addr_o = row_reg;
	assign line_sync_o = line_regs[10];
	assign frame_begin_o = fb_reg;
	assign row_clk_o = line_regs[9];
	assign row_clk_evod_o = line_regs[8];
	assign clamp_o = line_regs[7];
	assign sample_o = line_regs[6];
	assign read_o = line_regs[5];
	assign calib_o = line_regs[4];
	assign latch_o = line_regs[3];
	assign sparse_sync_o = line_regs[2];
	assign dig_sync_marker_o = dmk_reg;
	assign analog_clk_o = aclk_reg;
	assign analog_marker_out_o = amk_reg;

endmodule : prs_main

// ### design/prs_pkg.sv
// Constants shared by the pixel readout main sequencer and its pattern rings.
// Assumes a single 100 MHz core clock and configuration held stable by the test port.
package prs_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int LINE_CYC = 16;
	localparam int LINE_TIME_NS = 200;
	localparam int MARGIN_NS = 10;
	localparam int MARGIN_CYC = (MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FRAME_LINES = 928;
	localparam int NUM_COLS = 960;
	localparam int RST_LINE_TICKS = 2;
	localparam int LOAD_LINES = 8;
	localparam int SPARSE_LOAD_LINE = LOAD_LINES - 5;
	localparam int MK_START = 2;
	localparam int MK_LEN = 4;

	localparam logic [3:0] PHASE_LAST = 4'hf;
	localparam logic [3:0] PHASE_ROW_FALL = 4'h8;
	localparam logic [3:0] PHASE_FUNC_END = 4'(LINE_CYC - 1 - MARGIN_CYC);
	localparam logic [9:0] ROW_LAST = 10'(FRAME_LINES - 1);
	localparam logic [3:0] LOAD_LAST = 4'(LOAD_LINES - 1);
	localparam logic [3:0] SPARSE_LINE = 4'(SPARSE_LOAD_LINE);
	localparam logic [1:0] RST_TICKS = 2'(RST_LINE_TICKS);
	localparam logic [2:0] MK_FIRST = 3'h1;
	localparam logic [2:0] MK_END = 3'(MK_START + MK_LEN - 1);

	localparam logic [15:0] RING_RST = 16'h0000;
	localparam logic [9:0] ROW_RST = 10'h000;
	localparam logic [3:0] PHASE_RST = 4'h0;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RESET,
		ST_LOAD,
		ST_RUN
	} prs_state_t;

endpackage : prs_pkg

// ### design/prs_ring.sv
// Recirculating pattern register: one bit per line phase.
// Assumes load coincides with the last phase so bit 0 lines up with phase 0.
`timescale 1ns/100ps
module prs_ring
	import prs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Control
	input wire logic load_i,
	input wire logic [15:0] pattern_i,
	// Output
	output logic bit_o
);

	logic [15:0] ring_reg;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ring_reg <= RING_RST;
		else if (load_i)
			ring_reg <= pattern_i;
		else
			ring_reg <= {ring_reg[0], ring_reg[15:1]};
	end

	assign bit_o = ring_reg[0];

endmodule : prs_ring

// ### sim/prs_ctrl_model.sv
// Acquisition controller model: start token and analogue readout pin.
// Assumes the bench pulses req_i for one cycle per start token.
`timescale 1ns/100ps
module prs_ctrl_model
	import prs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Bench commands
	input wire logic req_i,
	input wire logic spk_i,
	// Controller pins
	output logic start_o,
	output logic speak_o
);
	// Four lines: two line ticks plus sync latency and slack
	logic [6:0] cnt_reg;
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			cnt_reg <= 7'h00;
		else if (req_i)
			cnt_reg <= 7'(4 * LINE_CYC);
		else if (cnt_reg != 7'h00)
			cnt_reg <= cnt_reg - 7'h01;
	end
	assign start_o = (cnt_reg != 7'h00);
	assign speak_o = spk_i;
endmodule : prs_ctrl_model

// ### sim/prs_main_monitor.sv
// Checker for the main sequencer, bound onto prs_main.
// Assumes one clock domain and the sequencer's port names.
`timescale 1ns/100ps
module prs_main_monitor
	import prs_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Watched outputs
	input wire logic seq_rst_a_n_o,
	input wire logic seq_rst_d_n_o,
	input wire logic pwr_on_o,
	input wire logic load_hold_o,
	input wire logic readout_active_o,
	input wire logic [9:0] row_addr_o,
	input wire logic line_sync_o,
	input wire logic frame_begin_o,
	input wire logic row_clk_evod_o,
	input wire logic sample_o,
	input wire logic dig_sync_marker_o,
	input wire logic analog_clk_o,
	input wire logic analog_marker_out_o
);
	logic started_reg;
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			started_reg <= 1'b0;
		else if (!seq_rst_a_n_o)
			started_reg <= 1'b1;
	end
	////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	a_dig_marker: assert property (frame_begin_o |-> ##2 dig_sync_marker_o[*4] ##1 !dig_sync_marker_o)
		else $error("digital marker shape wrong");
	a_ana_marker: assert property (analog_marker_out_o |-> frame_begin_o)
		else $error("analogue marker off frame");
	a_clk_running: assert property (started_reg |=> analog_clk_o != $past(analog_clk_o))
		else $error("analogue clock stalled");
	a_rst_pair: assert property (seq_rst_a_n_o == seq_rst_d_n_o)
		else $error("sequencer resets differ");
	a_rst_stops: assert property (!seq_rst_a_n_o |-> !readout_active_o && !load_hold_o)
		else $error("running during reset");
	a_pwr_sticky: assert property (pwr_on_o |=> pwr_on_o)
		else $error("power on dropped");
	a_hold_run: assert property ($fell(load_hold_o) && seq_rst_a_n_o |-> ##[0:2] readout_active_o)
		else $error("no readout after hold");
	a_line_period: assert property (line_sync_o |-> ##16 (line_sync_o || !readout_active_o))
		else $error("line period wrong");
	a_sample_line: assert property (sample_o == line_sync_o)
		else $error("sample off line start");
	a_row_step: assert property (line_sync_o |-> ##16 (!readout_active_o ||
		row_addr_o == (($past(row_addr_o, 16) == ROW_LAST) ? ROW_RST : $past(row_addr_o, 16) + 10'h001)))
		else $error("row step wrong");
	a_evod_toggle: assert property (line_sync_o |-> ##16 (!readout_active_o ||
		row_clk_evod_o != $past(row_clk_evod_o, 16)))
		else $error("even odd clock stuck");
	a_frame_row: assert property (frame_begin_o |-> line_sync_o && row_addr_o == ROW_RST)
		else $error("frame not at row zero");
endmodule : prs_main_monitor
bind prs_main prs_main_monitor prs_main_monitor_inst (.clk_i, .resetn_i, .seq_rst_a_n_o,
	.seq_rst_d_n_o, .pwr_on_o, .load_hold_o, .readout_active_o, .row_addr_o, .line_sync_o,
	.frame_begin_o, .row_clk_evod_o, .sample_o, .dig_sync_marker_o, .analog_clk_o,
	.analog_marker_out_o);

// ### sim/tb_top.sv
// Self-checking bench for the main sequencer.
// Assumes the controller model drives start and speak pins.
`timescale 1ns/100ps
module tb_top;
	import prs_pkg::*;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic req = 1'b0;
	logic spk = 1'b1;
	logic start_i, speak_i;
	logic [15:0] clamp_pat_i = 16'h8003;
	logic [15:0] read_pat_i = 16'h0ff0;
	logic [15:0] calib_pat_i = 16'h1248;
	logic [15:0] latch_pat_i = 16'hc001;
	logic [15:0] sparse_pat_i = 16'h80f0;
	logic [959:0] disc_mask_i = {480{2'b10}};
	logic [959:0] disc_raw_i = '1;
	logic [959:0] disc_out_o;
	logic seq_rst_a_n_o, seq_rst_d_n_o, pwr_on_o, load_hold_o, readout_active_o;
	logic [9:0] row_addr_o;
	logic line_sync_o, frame_begin_o, row_clk_o, row_clk_evod_o, clamp_o, sample_o;
	logic read_o, calib_o, latch_o, sparse_sync_o, dig_sync_marker_o;
	logic analog_clk_o, analog_marker_out_o;
	int compares = 0;
	int miscompares = 0;
	always #5 clk_i = ~clk_i;
	prs_main prs_main_inst (.*);
	prs_ctrl_model prs_ctrl_model_inst (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
		.spk_i(spk), .start_o(start_i), .speak_o(speak_i));
	////////////////////////////////////////
	task automatic chk(input logic [959:0] got, input logic [959:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : chk
	task automatic t_start();
		int i;
		@(posedge clk_i) req <= 1'b1;
		@(posedge clk_i) req <= 1'b0;
		for (i = 0; i < 80 && seq_rst_a_n_o; i++) @(negedge clk_i);
		chk({seq_rst_a_n_o, seq_rst_d_n_o, pwr_on_o, load_hold_o, readout_active_o}, 5'h04, "rst");
		for (i = 0; i < 120 && !load_hold_o; i++) @(negedge clk_i);
		chk({load_hold_o, readout_active_o}, 2'b10, "hold");
		for (i = 0; i < 200 && !readout_active_o; i++) @(negedge clk_i);
		chk({load_hold_o, readout_active_o}, 2'b01, "run");
		for (i = 0; i < 4 && !frame_begin_o; i++) @(negedge clk_i);
		chk({frame_begin_o, row_addr_o}, 11'h400, "frame");
		chk(analog_marker_out_o, spk, "amark");
		@(negedge clk_i);
		chk(disc_out_o, ~disc_mask_i, "mask");
		$display("test start done");
	endtask : t_start
	task automatic t_frame();
		int i;
		@(posedge clk_i) spk <= 1'b0;
		@(negedge clk_i);
		for (i = 2; i < 15000 && !frame_begin_o; i++) @(negedge clk_i);
		chk(i, FRAME_LINES * LINE_CYC, "period");
		chk({analog_marker_out_o, row_addr_o}, 11'h000, "amark off");
		repeat (2) @(negedge clk_i);
		chk(dig_sync_marker_o, 1'b1, "dmark");
		$display("test frame done");
	endtask : t_frame
	task automatic t_pattern();
		int k;
		for (k = 0; k < 20 && !line_sync_o; k++) @(negedge clk_i);
		for (k = 0; k < 16; k++)
		begin
			chk({clamp_o, read_o, calib_o, latch_o, sparse_sync_o}, (k == 15) ? 5'h00 :
				{clamp_pat_i[k], read_pat_i[k], calib_pat_i[k], latch_pat_i[k], sparse_pat_i[k]}, "pat");
			chk(row_clk_o, k < 8, "row clock");
			@(negedge clk_i);
		end
		$display("test pattern done");
	endtask : t_pattern
	task automatic t_mask();
		@(posedge clk_i) disc_mask_i <= ~disc_mask_i;
		repeat (20) @(negedge clk_i);
		// Old mask still applied: its inverse equals the new mask
		chk(disc_out_o, disc_mask_i, "mask held");
		repeat (100) @(negedge clk_i);
		t_start();
		$display("test mask done");
	endtask : t_mask
	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////
	initial
	begin
		#(30000 * 10);
		miscompares++;
		print_verdict();
	end
	initial
	begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(negedge clk_i);
		chk({seq_rst_a_n_o, pwr_on_o, readout_active_o, row_addr_o}, 13'h1000, "reset");
		t_start();
		t_frame();
		t_pattern();
		t_mask();
		print_verdict();
	end
endmodule : tb_top
